/* rtl/eicfg_idx_if.sv */
// carrier between the top and the index detector
`timescale 1ns/1ns
interface eicfg_idx_if;
    import eicfg_pkg::*;
    logic a_lvl;
    logic b_lvl;
    logic n_lvl;
    logic pol_index;
    logic pol_a;
    logic pol_b;
    logic skip_channel_qualification;
    eicfg_sens_e index_sensitivity;
    logic evt;
    modport det (
        input a_lvl, b_lvl, n_lvl, pol_index, pol_a, pol_b,
        input skip_channel_qualification, index_sensitivity,
        output evt
    );
    modport top (
        output a_lvl, b_lvl, n_lvl, pol_index, pol_a, pol_b,
        output skip_channel_qualification, index_sensitivity,
        input evt
    );
endinterface

/* rtl/eicfg_index_det.sv */
// qualified index event detector
`timescale 1ns/1ns
module eicfg_index_det
    import eicfg_pkg::*;
(
    // clock, reset and enable
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // synchronised channels and config
    eicfg_idx_if.det idx
);
    logic n_prev_q;
    logic n_prev_d;
    logic active;
    logic prev_active;
    logic trig;
    logic qual;

    always_comb begin
        n_prev_d = n_prev_q;
        if (clk_en_in) begin
            n_prev_d = idx.n_lvl;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            n_prev_q <= 1'b0;
        end else begin
            n_prev_q <= n_prev_d;
        end
    end

    always_comb begin
        // RL6 index polarity
        active = ~(idx.n_lvl ^ idx.pol_index);
        prev_active = ~(n_prev_q ^ idx.pol_index);
        // RL7 RL8 sensitivity select
        unique case (idx.index_sensitivity)
            EICFG_SENS_LEVEL: trig = active;
            EICFG_SENS_TO_ACTIVE: trig = active & ~prev_active;
            EICFG_SENS_TO_INACTIVE: trig = ~active & prev_active;
            EICFG_SENS_BOTH: trig = active ^ prev_active;
        endcase
        // RL9 RL10 RL11 channel qualification
        qual = idx.skip_channel_qualification |
               ((idx.a_lvl == idx.pol_a) & (idx.b_lvl == idx.pol_b));
        // RL13 single qualified pulse
        idx.evt = trig & qual & clk_en_in;
    end

    AST_LEVEL_PRESENT: assert property (@(posedge mclk_in) disable iff (srst_in) // RL7
        (clk_en_in && idx.index_sensitivity == EICFG_SENS_LEVEL &&
         idx.skip_channel_qualification && (idx.n_lvl == idx.pol_index)) |-> idx.evt)
        else $error("level index not present");

    AST_TO_ACTIVE: assert property (@(posedge mclk_in) disable iff (srst_in) // RL8
        (clk_en_in && $past(clk_en_in) && !$past(srst_in) &&
         idx.index_sensitivity == EICFG_SENS_TO_ACTIVE && idx.skip_channel_qualification &&
         $stable(idx.pol_index) && $changed(idx.n_lvl)) |->
        (idx.evt == (idx.n_lvl == idx.pol_index)))
        else $error("active edge not detected");

    AST_BOTH_EDGES: assert property (@(posedge mclk_in) disable iff (srst_in) // RL8
        (clk_en_in && $past(clk_en_in) && !$past(srst_in) &&
         idx.index_sensitivity == EICFG_SENS_BOTH && idx.skip_channel_qualification) |->
        (idx.evt == $changed(idx.n_lvl)))
        else $error("both edge event wrong");

    AST_QUAL_BLOCK: assert property (@(posedge mclk_in) disable iff (srst_in) // RL9 RL10 RL11
        (!idx.skip_channel_qualification &&
         ((idx.a_lvl != idx.pol_a) || (idx.b_lvl != idx.pol_b))) |-> !idx.evt)
        else $error("unqualified index accepted");

    AST_INACTIVE_EDGE: assert property (@(posedge mclk_in) disable iff (srst_in) // RL8
        (clk_en_in && $past(clk_en_in) && !$past(srst_in) &&
         idx.index_sensitivity == EICFG_SENS_TO_INACTIVE && idx.skip_channel_qualification &&
         $stable(idx.pol_index)) |->
        (idx.evt == ($changed(idx.n_lvl) && idx.n_lvl != idx.pol_index)))
        else $error("inactive edge wrong");
endmodule // eicfg_index_det

/* rtl/eicfg_pkg.sv */
// constants and types shared by the encoder index event block
package eicfg_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] EICFG_IDX_INPUT_CONFIG = 8'h07;
    localparam logic [7:0] EICFG_IDX_RESET_VALUE = 8'h08;
    localparam logic [7:0] EICFG_IDX_POSITION = 8'h09;
    localparam logic [7:0] EICFG_IDX_LATCH = 8'h0a;
    localparam logic [7:0] EICFG_ADDR_INPUT_CONFIG = {EICFG_IDX_INPUT_CONFIG[5:0], 2'b00};
    localparam logic [7:0] EICFG_ADDR_RESET_VALUE = {EICFG_IDX_RESET_VALUE[5:0], 2'b00};
    localparam logic [7:0] EICFG_ADDR_POSITION = {EICFG_IDX_POSITION[5:0], 2'b00};
    localparam logic [7:0] EICFG_ADDR_LATCH = {EICFG_IDX_LATCH[5:0], 2'b00};
    // reset values
    localparam logic [31:0] EICFG_RST_INPUT_CONFIG = 32'h00000400;
    localparam logic [31:0] EICFG_RST_RESET_VALUE = 32'h00000000;
    localparam logic [31:0] EICFG_RST_POSITION = 32'h00000000;
    // field positions in encoder_input_config
    localparam int unsigned EICFG_BIT_SEL_DECIMAL = 0;
    localparam int unsigned EICFG_BIT_CLEAR_ON_INDEX = 1;
    localparam int unsigned EICFG_BIT_ACT_CONT = 2;
    localparam int unsigned EICFG_BIT_ACT_ONCE = 3;
    localparam int unsigned EICFG_BIT_POL_INDEX = 4;
    localparam int unsigned EICFG_BIT_SENS_LO = 5;
    localparam int unsigned EICFG_BIT_SENS_HI = 6;
    localparam int unsigned EICFG_BIT_POL_A = 7;
    localparam int unsigned EICFG_BIT_POL_B = 8;
    localparam int unsigned EICFG_BIT_SKIP_QUAL = 9;
    localparam int unsigned EICFG_BIT_LATCH_POS = 10;
    // index sensitivity modes, encoded 0..3 in declaration order
    typedef enum logic [1:0] {
        EICFG_SENS_LEVEL,
        EICFG_SENS_TO_ACTIVE,
        EICFG_SENS_TO_INACTIVE,
        EICFG_SENS_BOTH
    } eicfg_sens_e;
endpackage

/* rtl/eicfg_top.sv */
// encoder index event config: apb registers, position counter, index actions
// Summary of operation
// RL1: constant format bit selects binary (0) or decimal (1) encoder constant.
// RL2: clear-on-index loads position with reset value on qualifying index events.
// RL3: software keeps clear-on-index off during closed-loop operation.
// RL4: continuous bit performs clear or latch on every qualifying index event.
// RL5: one-shot bit acts on the next qualifying event, then self-clears.
// RL6: index polarity bit selects low-active (0) or high-active (1) index.
// RL7: sensitivity 0 means event present while index sits active.
// RL8: sensitivity 1 to active, 2 to inactive, 3 either transition.
// RL9: A channel must match its polarity bit unless qualification skipped.
// RL10: B channel must match its polarity bit unless qualification skipped.
// RL11: skip bit set accepts index regardless of A and B levels.
// RL12: config register resets to 0x00000400.
// RL13: one synchronised qualified pulse drives all clear and latch actions.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module eicfg_top
    import eicfg_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // encoder pins
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic enc_n_in,
    // status
    output logic enc_const_decimal_out,
    output logic index_event_out,
    output logic [31:0] enc_position_out
);
    eicfg_idx_if idx ();

    // pin synchronisers: stage one feeds only stage two
    logic [2:0] sync1_q;
    logic [2:0] sync1_d;
    logic [2:0] sync2_q;
    logic [2:0] sync2_d;
    logic [1:0] ab_prev_q;
    logic [1:0] ab_prev_d;

    always_comb begin
        sync1_d = sync1_q;
        sync2_d = sync2_q;
        ab_prev_d = ab_prev_q;
        if (clk_en_in) begin
            sync1_d = {enc_n_in, enc_b_in, enc_a_in};
            sync2_d = sync1_q;
            ab_prev_d = sync2_q[1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            ab_prev_q <= 2'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            ab_prev_q <= ab_prev_d;
        end
    end

    // registers
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] rst_val_q;
    logic [31:0] rst_val_d;
    logic [31:0] pos_q;
    logic [31:0] pos_d;
    logic [31:0] latch_q;
    logic [31:0] latch_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic evt_q;
    logic evt_d;

    logic apb_access;
    logic apb_setup;
    logic wr_cfg;
    logic wr_rst_val;
    logic act;
    logic [1:0] step;

    // gray step decode: bit1 valid, bit0 up
    function automatic logic [1:0] eicfg_quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [1:0] res;
        res = 2'h0;
        unique case ({prev, cur})
            4'h1, 4'h7, 4'he, 4'h8: res = 2'h3;
            4'h2, 4'hb, 4'hd, 4'h4: res = 2'h2;
            default: res = 2'h0;
        endcase
        return res;
    endfunction

    function automatic logic eicfg_mapped(input logic [7:0] addr);
        return (addr == EICFG_ADDR_INPUT_CONFIG) || (addr == EICFG_ADDR_RESET_VALUE) ||
               (addr == EICFG_ADDR_POSITION) || (addr == EICFG_ADDR_LATCH);
    endfunction

    assign idx.a_lvl = sync2_q[0];
    assign idx.b_lvl = sync2_q[1];
    assign idx.n_lvl = sync2_q[2];
    assign idx.pol_index = cfg_q[EICFG_BIT_POL_INDEX];
    assign idx.pol_a = cfg_q[EICFG_BIT_POL_A];
    assign idx.pol_b = cfg_q[EICFG_BIT_POL_B];
    assign idx.skip_channel_qualification = cfg_q[EICFG_BIT_SKIP_QUAL];
    assign idx.index_sensitivity = eicfg_sens_e'(cfg_q[EICFG_BIT_SENS_HI:EICFG_BIT_SENS_LO]);

    eicfg_index_det u_det (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .clk_en_in(clk_en_in),
        .idx(idx)
    );

    // zero wait state while enabled; a low enable also stalls the bus
    assign pready_out = psel_in & penable_in & clk_en_in;
    assign pslverr_out = psel_in & penable_in & ~eicfg_mapped(paddr_in);
    assign prdata_out = rdata_q;
    // RL1 format flag
    assign enc_const_decimal_out = cfg_q[EICFG_BIT_SEL_DECIMAL];
    assign index_event_out = evt_q;
    assign enc_position_out = pos_q;

    always_comb begin
        apb_access = psel_in & penable_in & clk_en_in;
        apb_setup = psel_in & ~penable_in & clk_en_in;
        wr_cfg = apb_access & pwrite_in & (paddr_in == EICFG_ADDR_INPUT_CONFIG);
        wr_rst_val = apb_access & pwrite_in & (paddr_in == EICFG_ADDR_RESET_VALUE);
        // RL4 RL5 action gate
        act = idx.evt & (cfg_q[EICFG_BIT_ACT_CONT] | cfg_q[EICFG_BIT_ACT_ONCE]);
        step = eicfg_quad_step(ab_prev_q, sync2_q[1:0]);

        cfg_d = cfg_q;
        rst_val_d = rst_val_q;
        pos_d = pos_q;
        latch_d = latch_q;
        rdata_d = rdata_q;
        evt_d = evt_q;
        if (clk_en_in) begin
            evt_d = idx.evt;
            // RL5 one-shot self clear, a same-cycle write wins
            if (act && cfg_q[EICFG_BIT_ACT_ONCE]) begin
                cfg_d[EICFG_BIT_ACT_ONCE] = 1'b0;
            end
            if (wr_cfg) begin
                cfg_d = pwdata_in;
            end
            if (wr_rst_val) begin
                rst_val_d = pwdata_in;
            end
            // RL2 reload takes priority over counting
            if (act && cfg_q[EICFG_BIT_CLEAR_ON_INDEX]) begin
                pos_d = rst_val_q;
            end else if (step[1]) begin
                pos_d = step[0] ? pos_q + 32'h1 : pos_q - 32'h1;
            end
            // latch catches the position before any reload
            if (act && cfg_q[EICFG_BIT_LATCH_POS]) begin
                latch_d = pos_q;
            end
            // read data is captured in setup so it comes from flops
            if (apb_setup && !pwrite_in) begin
                unique case (paddr_in)
                    EICFG_ADDR_INPUT_CONFIG: rdata_d = cfg_q;
                    EICFG_ADDR_RESET_VALUE: rdata_d = rst_val_q;
                    EICFG_ADDR_POSITION: rdata_d = pos_q;
                    EICFG_ADDR_LATCH: rdata_d = latch_q;
                    default: rdata_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            // RL12 config reset value
            cfg_q <= EICFG_RST_INPUT_CONFIG;
            rst_val_q <= EICFG_RST_RESET_VALUE;
            pos_q <= EICFG_RST_POSITION;
            latch_q <= EICFG_RST_POSITION;
            rdata_q <= 32'h0;
            evt_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rst_val_q <= rst_val_d;
            pos_q <= pos_d;
            latch_q <= latch_d;
            rdata_q <= rdata_d;
            evt_q <= evt_d;
        end
    end

    sequence s_once_event;
        clk_en_in && idx.evt && cfg_q[EICFG_BIT_ACT_ONCE] && !wr_cfg;
    endsequence

    sequence s_once_gone;
        !cfg_q[EICFG_BIT_ACT_ONCE] ##1 (!cfg_q[EICFG_BIT_ACT_ONCE] || $past(wr_cfg));
    endsequence

    AST_RESET_CFG: assert property (@(posedge mclk_in) // RL12
        srst_in |=> (cfg_q == EICFG_RST_INPUT_CONFIG))
        else $error("config reset value wrong");

    AST_ONCE_SELF_CLEAR: assert property (@(posedge mclk_in) disable iff (srst_in) // RL5
        s_once_event |=> s_once_gone)
        else $error("one-shot bit not cleared");

    AST_RELOAD: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        (clk_en_in && act && cfg_q[EICFG_BIT_CLEAR_ON_INDEX]) |=> (pos_q == $past(rst_val_q)))
        else $error("position not reloaded");

    AST_NO_RELOAD_IDLE: assert property (@(posedge mclk_in) disable iff (srst_in) // RL4
        (clk_en_in && !cfg_q[EICFG_BIT_ACT_CONT] && !cfg_q[EICFG_BIT_ACT_ONCE] && !step[1])
        |=> $stable(pos_q))
        else $error("position moved without action");

    AST_CONT_KEEPS: assert property (@(posedge mclk_in) disable iff (srst_in) // RL4
        (clk_en_in && idx.evt && cfg_q[EICFG_BIT_ACT_CONT] && !cfg_q[EICFG_BIT_ACT_ONCE] &&
         !wr_cfg) |=> cfg_q[EICFG_BIT_ACT_CONT])
        else $error("continuous bit lost");

    AST_DECIMAL_FLAG: assert property (@(posedge mclk_in) disable iff (srst_in) // RL1
        wr_cfg |=> (enc_const_decimal_out == $past(pwdata_in[EICFG_BIT_SEL_DECIMAL])))
        else $error("format flag mismatch");

    AST_EVENT_OUT: assert property (@(posedge mclk_in) disable iff (srst_in) // RL13
        (clk_en_in && idx.evt) |=> index_event_out)
        else $error("index pulse not reported");

    // quadrature steps that a reload does not override
    sequence s_count_up;
        clk_en_in && step == 2'h3 && !(act && cfg_q[EICFG_BIT_CLEAR_ON_INDEX]);
    endsequence

    sequence s_count_down;
        clk_en_in && step == 2'h2 && !(act && cfg_q[EICFG_BIT_CLEAR_ON_INDEX]);
    endsequence

    AST_COUNT_UP: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        s_count_up |=> (pos_q == $past(pos_q) + 32'h1))
        else $error("position did not count up");

    AST_COUNT_DOWN: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        s_count_down |=> (pos_q == $past(pos_q) - 32'h1))
        else $error("position did not count down");

    AST_ACT_WITHOUT_CLEAR: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        (act && !cfg_q[EICFG_BIT_CLEAR_ON_INDEX] && !step[1]) |=> $stable(pos_q))
        else $error("position reloaded with clear disabled");

    AST_LATCH_OLD_POS: assert property (@(posedge mclk_in) disable iff (srst_in) // RL4
        (act && cfg_q[EICFG_BIT_LATCH_POS]) |=> (latch_q == $past(pos_q)))
        else $error("latch missed the pre-reload position");

    AST_LATCH_HELD: assert property (@(posedge mclk_in) disable iff (srst_in) // RL4
        !act |=> $stable(latch_q))
        else $error("latch moved without action");

    AST_EVENT_ONLY: assert property (@(posedge mclk_in) disable iff (srst_in) // RL13
        (clk_en_in && !idx.evt) |=> !index_event_out)
        else $error("index pulse without event");

    AST_FREEZE_STATE: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        !clk_en_in |=> ($stable(cfg_q) && $stable(rst_val_q) &&
         $stable(pos_q) && $stable(latch_q)))
        else $error("state moved while frozen");

    AST_SYNC_TWO_STAGE: assert property (@(posedge mclk_in) disable iff (srst_in) // RL13
        ($past(clk_en_in) && $past(clk_en_in, 2) && !$past(srst_in) && !$past(srst_in, 2)) |->
        (sync2_q == $past({enc_n_in, enc_b_in, enc_a_in}, 2)))
        else $error("pin synchroniser depth wrong");

    AST_READ_CFG: assert property (@(posedge mclk_in) disable iff (srst_in) // RL12
        (apb_setup && !pwrite_in && paddr_in == EICFG_ADDR_INPUT_CONFIG) |=>
        (prdata_out == $past(cfg_q)))
        else $error("config read data wrong");

    AST_READ_POS: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        (apb_setup && !pwrite_in && paddr_in == EICFG_ADDR_POSITION) |=>
        (prdata_out == $past(pos_q)))
        else $error("position read data wrong");

    AST_WRITE_RST_VAL: assert property (@(posedge mclk_in) disable iff (srst_in) // RL2
        wr_rst_val |=> (rst_val_q == $past(pwdata_in)))
        else $error("reset value write lost");

    AST_ONCE_STAYS: assert property (@(posedge mclk_in) disable iff (srst_in) // RL5
        (!cfg_q[EICFG_BIT_ACT_ONCE] && !wr_cfg) |=> !cfg_q[EICFG_BIT_ACT_ONCE])
        else $error("one-shot bit set by hardware");
endmodule // eicfg_top

/* verif/eicfg_enc_model.sv */
// incremental quadrature encoder model with index channel
`timescale 1ns/1ns
module eicfg_enc_model (
    // clock
    input wire logic mclk_in,
    // encoder pins
    output logic enc_a_out,
    output logic enc_b_out,
    output logic enc_n_out
);
    logic [1:0] phase_q = 2'h0;
    initial begin
        enc_a_out = 1'b0;
        enc_b_out = 1'b0;
        enc_n_out = 1'b0;
    end
    // gray order on {b,a} is 00 01 11 10 when counting up; hold sets how slow
    task automatic step_up(input int hold);
        @(posedge mclk_in);
        phase_q <= phase_q + 2'h1;
        enc_b_out <= phase_q[1] ^ phase_q[0];
        enc_a_out <= ~phase_q[1];
        repeat (hold) @(posedge mclk_in);
    endtask
    task automatic set_ab(input logic a, input logic b);
        @(posedge mclk_in);
        enc_a_out <= a;
        enc_b_out <= b;
    endtask
    task automatic set_n(input logic v);
        @(posedge mclk_in);
        enc_n_out <= v;
    endtask
    // index stays active for len cycles, then settles long enough to be seen
    task automatic pulse_n(input logic act, input int len);
        set_n(act);
        repeat (len) @(posedge mclk_in);
        enc_n_out <= ~act;
        repeat (6) @(posedge mclk_in);
    endtask
endmodule // eicfg_enc_model

/* verif/eicfg_top_tb.sv */
// self-checking bench for the encoder index event block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module eicfg_top_tb;
    import eicfg_pkg::*;
    logic mclk_in = 1'b0, srst_in = 1'b1, clk_en_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, enc_position_out;
    logic pready_out, pslverr_out, enc_const_decimal_out, index_event_out;
    wire enc_a, enc_b, enc_n;
    int samples_checked = 0, miscompares = 0, evt_cnt = 0;
    eicfg_top dut (.mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .enc_a_in(enc_a),
        .enc_b_in(enc_b), .enc_n_in(enc_n), .enc_const_decimal_out(enc_const_decimal_out),
        .index_event_out(index_event_out), .enc_position_out(enc_position_out));
    eicfg_enc_model enc (.mclk_in(mclk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
        .enc_n_out(enc_n));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (index_event_out === 1'b1) evt_cnt <= evt_cnt + 1;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= ad;
        pwdata_in <= wd;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 50) miscompares++;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, ad, wd, rd, err);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, ad, 32'h0, rd, err);
        `CHK(nm, e, rd)
    endtask
    function automatic logic [31:0] cfg(logic clr, logic cont, logic once, logic pol,
        logic [1:0] sens, logic pa, logic pb, logic skip);
        return {21'h0, 1'b1, skip, pb, pa, sens, pol, once, cont, clr, 1'b0};
    endfunction
    task automatic t_reset();
        logic [31:0] rd;
        logic err;
        rd_chk("config", EICFG_ADDR_INPUT_CONFIG, 32'h00000400);
        rd_chk("reset value", EICFG_ADDR_RESET_VALUE, 32'h0);
        apb(1'b0, 8'h40, 32'h0, rd, err);
        `CHK("unmapped err", 1'b1, err)
        `CHK("decimal", 1'b0, enc_const_decimal_out)
        wr(EICFG_ADDR_INPUT_CONFIG, 32'h00000401);
        @(posedge mclk_in);
        `CHK("decimal", 1'b1, enc_const_decimal_out)
        wr(EICFG_ADDR_INPUT_CONFIG, 32'h00000400);
        wr(EICFG_ADDR_RESET_VALUE, 32'h00000055);
    endtask
    // every polarity and sensitivity, clear on every event
    task automatic t_sens();
        int exp_n [4] = '{4, 1, 1, 2};
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                enc.set_n(~p[0]);
                wr(EICFG_ADDR_INPUT_CONFIG, cfg(1'b1, 1'b1, 1'b0, p[0], s[1:0], 1'b0, 1'b0, 1'b1));
                repeat (6) @(posedge mclk_in);
                evt_cnt = 0;
                enc.step_up(2);
                enc.pulse_n(p[0], 4);
                `CHK("events", exp_n[s], evt_cnt)
                `CHK("position", 32'h55, enc_position_out)
            end
        end
    endtask
    // clear only when enabled, once self-clears, latch keeps old position
    task automatic t_actions();
        logic [31:0] c [3];
        logic [31:0] ep [3] = '{32'h56, 32'h57, 32'h55};
        c[0] = cfg(1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
        c[1] = cfg(1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
        c[2] = cfg(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
        enc.set_n(1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(EICFG_ADDR_INPUT_CONFIG, c[i]);
            evt_cnt = 0;
            enc.step_up(2);
            enc.pulse_n(1'b1, 3);
            `CHK("events", 1, evt_cnt)
            `CHK("position", ep[i], enc_position_out)
        end
        rd_chk("latch", EICFG_ADDR_LATCH, 32'h58);
        rd_chk("config", EICFG_ADDR_INPUT_CONFIG, c[1]);
        enc.step_up(2);
        enc.pulse_n(1'b1, 3);
        `CHK("position", 32'h56, enc_position_out)
    endtask
    task automatic t_qual();
        for (int q = 0; q < 5; q++) begin
            wr(EICFG_ADDR_INPUT_CONFIG, cfg(1'b0, 1'b0, 1'b0, 1'b1, 2'h1, q[0], q[1], q[2]));
            for (int v = 0; v < 4; v++) begin
                enc.set_ab(v[0], v[1]);
                repeat (4) @(posedge mclk_in);
                evt_cnt = 0;
                enc.pulse_n(1'b1, 3);
                `CHK("qualified", int'(q[2] || v[1:0] == q[1:0]), evt_cnt)
            end
        end
    endtask
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        t_reset();
        t_sens();
        t_actions();
        t_qual();
        report_and_stop();
    end
endmodule // eicfg_top_tb
